// ### verilog/ssr_pkg.sv
// Package for the receiver channel status register bank.
// Assumes a single core clock domain and an 8-bit register read port.
package ssr_pkg;

  // Register offsets of the read-only status bank.
  localparam logic [7:0] SSR_ADDR_RATE_ACC  = 8'h10;
  localparam logic [7:0] SSR_ADDR_WORD_LEN  = 8'h11;

  // Positions of the captured fields inside the status block.
  localparam int SSR_CS_RATE_LSB   = 24;
  localparam int SSR_CS_ACC_LSB    = 28;
  localparam int SSR_CS_MAXLEN_BIT = 32;
  localparam int SSR_CS_LEN_LSB    = 33;
  localparam int SSR_CS_ORIG_LSB   = 36;
  localparam int SSR_CS_BITS       = 40;

  // Values after reset.
  localparam logic [3:0] SSR_RATE_RST   = 4'h1;
  localparam logic [1:0] SSR_ACC_RST    = 2'h3;
  localparam logic       SSR_MAXLEN_RST = 1'b1;
  localparam logic [2:0] SSR_LEN_RST    = 3'h0;
  localparam logic [3:0] SSR_ORIG_RST   = 4'h0;

  // Audio sample width on the interface.
  localparam int SSR_SAMPLE_W = 24;

  // Captured status fields as they travel together.
  typedef struct packed {
    logic [3:0] original_rate_code;
    logic [2:0] recovered_length_code;
    logic       max_length_select;
    logic [1:0] clock_accuracy_level;
    logic [3:0] indicated_rate_code;
  } ssr_status_t;

  localparam ssr_status_t SSR_STATUS_RST = '{
    original_rate_code:    SSR_ORIG_RST,
    recovered_length_code: SSR_LEN_RST,
    max_length_select:     SSR_MAXLEN_RST,
    clock_accuracy_level:  SSR_ACC_RST,
    indicated_rate_code:   SSR_RATE_RST};

  // Receiver flags that travel as a group.
  typedef struct packed {
    logic unlock;
    logic invalid;
    logic link_error_flag;
  } ssr_flags_t;

endpackage : ssr_pkg

// ### verilog/ssr_truncate.sv
// Audio truncation to the recovered word length.
// Assumes the status fields come straight from the register bank.
module ssr_truncate
  import ssr_pkg::*;
#(
  parameter int SAMPLE_W = SSR_SAMPLE_W
) (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Control and status.
  input  wire logic                truncation_override,
  input  wire ssr_status_t         status,
  // Audio.
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                sample_in_valid,
  output logic      [SAMPLE_W-1:0] sample_out,
  output logic                     sample_out_valid
);

  // The length table assumes a 24-bit sample word.
  if (SAMPLE_W != 24) begin : g_bad_width
    $error("ssr_truncate needs a 24-bit sample width");
  end

  // Maps the length code and range bit to a kept width; zero means none.
  function automatic logic [4:0] kept_bits(input logic [2:0] code,
                                           input logic       max24);
    logic [4:0] base;
    base = 5'h0;
    unique case (code)
      3'h1:    base = 5'h10;
      3'h2:    base = 5'h12;
      3'h4:    base = 5'h13;
      3'h5:    base = 5'h14;
      3'h6:    base = 5'h11;
      default: base = 5'h0; // Not indicated or reserved codes.
    endcase
    if (base != 5'h0 && max24) begin
      base = base + 5'h4;
    end
    return base;
  endfunction

  logic [4:0]          keep;   // Bits kept from the top of the sample.
  logic [SAMPLE_W-1:0] mask;   // Ones at the kept positions.

  // Build the keep mask; the override leaves the full word untouched.
  always_comb begin
    keep = kept_bits(status.recovered_length_code,
                     status.max_length_select);
    mask = '1;
    if (!truncation_override && keep != 5'h0) begin
      for (int i = 0; i < SAMPLE_W; i++) begin
        mask[i] = (i >= (SAMPLE_W - int'(keep)));
      end
    end
  end

  // Register the truncated sample so the data output comes from a flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out       <= '0;
      sample_out_valid <= 1'b0;
    end else begin
      sample_out       <= sample_in & mask;
      sample_out_valid <= sample_in_valid;
    end
  end

endmodule // ssr_truncate

// ### verilog/ssr_status_regs.sv
// Receiver channel status register bank and status flag outputs.
// Assumes the bit decoder upstream delivers one channel status bit per
// pulse for the first sub-frame, with a block-start marker, and delivers
// the lock, validity and error indications as synchronous levels/pulses.
module ssr_status_regs
  import ssr_pkg::*;
#(
  parameter int SAMPLE_W = SSR_SAMPLE_W
) (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Recovered status bit stream, first channel only.
  input  wire logic                cs_bit,
  input  wire logic                cs_bit_valid,
  input  wire logic                cs_block_start,
  input  wire logic                cs_subframe_a,
  // Receiver indications.
  input  wire logic                rx_unlocked,
  input  wire logic                rx_data_invalid,
  input  wire logic                preamble_err,
  input  wire logic                parity_err,
  input  wire logic                biphase_err,
  input  wire logic                hw_mode,
  // Register read port.
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_rd,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  // Control.
  input  wire logic                truncation_override,
  // Audio.
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                sample_in_valid,
  output logic      [SAMPLE_W-1:0] sample_out,
  output logic                     sample_out_valid,
  // Flag outputs.
  output ssr_flags_t               flags,
  output logic                     status_block_update_irq,
  output logic                     general_output_pin,
  output logic                     chip_select_pin,
  output logic                     chip_select_pin_oe,
  output logic                     serial_clock_pin,
  output logic                     serial_clock_pin_oe
);

  localparam int CNT_W = $clog2(SSR_CS_BITS + 1);

  logic [1:0]             rst_sync;        // Reset release synchroniser.
  logic                   rst_n;           // Synchronised reset.
  logic [SSR_CS_BITS-1:0] shadow_reg;      // Block being received.
  logic [CNT_W-1:0]       bit_cnt_reg;     // Bits received this block.
  logic                   differs_reg;     // A bit differed so far.
  ssr_status_t            status_reg;      // Visible register contents.
  ssr_status_t            incoming;        // Fields of the shadow block.
  logic                   last_bit;        // Final captured bit arrives.
  logic                   bit_differs;     // Current bit differs.
  logic [CNT_W-1:0]       bit_idx;         // Index of the current bit.

  // Release the asynchronous reset through two flops.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Only the captured range of the block matters; bits past 39 are
  // ignored, which keeps the shadow small at the cost of missing
  // changes in the rest of the block.
  assign bit_idx  = (cs_block_start) ? '0 : bit_cnt_reg;
  assign last_bit = cs_bit_valid && cs_subframe_a &&
                    bit_idx == CNT_W'(SSR_CS_BITS - 1);

  // Lays the stored fields out in block order from bit 24 upward. Bits
  // 31:30 are not kept, so they read as zero here and are never compared.
  function automatic logic [15:0] block_image(input ssr_status_t s);
    return {s.original_rate_code, s.recovered_length_code,
            s.max_length_select, 2'h0, s.clock_accuracy_level,
            s.indicated_rate_code};
  endfunction

  logic [15:0] held_img;  // Stored fields in block bit order.
  logic [3:0]  img_idx;   // Place of the current bit in that image.

  // Compare the incoming bit with the stored register value; only bits
  // that the registers hold can make a block count as different.
  always_comb begin
    held_img    = block_image(status_reg);
    img_idx     = 4'(bit_idx - CNT_W'(SSR_CS_RATE_LSB));
    bit_differs = 1'b0;
    if (cs_bit_valid && cs_subframe_a &&
        bit_idx >= CNT_W'(SSR_CS_RATE_LSB) &&
        bit_idx <  CNT_W'(SSR_CS_BITS) &&
        (bit_idx <  CNT_W'(SSR_CS_ACC_LSB + 2) ||
         bit_idx >= CNT_W'(SSR_CS_MAXLEN_BIT))) begin
      bit_differs = cs_bit != held_img[img_idx];
    end
  end

  // Shift in status bits of the first sub-frame only.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg  <= '0;
      bit_cnt_reg <= '0;
    end else if (cs_bit_valid && cs_subframe_a) begin
      if (bit_idx < CNT_W'(SSR_CS_BITS)) begin
        shadow_reg[bit_idx] <= cs_bit;
        bit_cnt_reg         <= bit_idx + CNT_W'(1);
      end
    end else if (cs_block_start) begin
      bit_cnt_reg <= '0;
    end
  end

  // Track whether anything in this block differs from the registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      differs_reg <= 1'b0;
    end else if (last_bit) begin
      differs_reg <= 1'b0;
    end else if (cs_block_start && cs_bit_valid && cs_subframe_a) begin
      differs_reg <= bit_differs;
    end else if (cs_block_start) begin
      differs_reg <= 1'b0;
    end else if (bit_differs) begin
      differs_reg <= 1'b1;
    end
  end

  // Assemble the new register image including the final bit.
  always_comb begin
    logic [SSR_CS_BITS-1:0] blk;
    blk = shadow_reg;
    blk[SSR_CS_BITS-1] = cs_bit;
    // Fields are picked one by one because bits 31:30 sit between them
    // in the block and have no place in the registers.
    incoming.original_rate_code    = blk[SSR_CS_ORIG_LSB +: 4];
    incoming.recovered_length_code = blk[SSR_CS_LEN_LSB +: 3];
    incoming.max_length_select     = blk[SSR_CS_MAXLEN_BIT];
    incoming.clock_accuracy_level  = blk[SSR_CS_ACC_LSB +: 2];
    incoming.indicated_rate_code   = blk[SSR_CS_RATE_LSB +: 4];
  end

  // Registers change only when a differing block has completed.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= SSR_STATUS_RST;
    end else if (last_bit && (differs_reg || bit_differs)) begin
      status_reg <= incoming;
    end
  end

  // Update interrupt: set at the end of a differing block, dropped on a status register
  // read or on the first differing bit of a later block.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_block_update_irq <= 1'b0;
    end else if (last_bit && (differs_reg || bit_differs)) begin
      status_block_update_irq <= 1'b1;
    end else if (bit_differs && !differs_reg) begin
      status_block_update_irq <= 1'b0;
    end else if (reg_rd && (reg_addr == SSR_ADDR_RATE_ACC ||
                            reg_addr == SSR_ADDR_WORD_LEN)) begin
      status_block_update_irq <= 1'b0;
    end
  end

  // Read multiplexer; writes are not decoded and so have no effect.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SSR_ADDR_RATE_ACC: reg_rdata <= {2'h0,
          status_reg.clock_accuracy_level,
          status_reg.indicated_rate_code};
        SSR_ADDR_WORD_LEN: reg_rdata <= {status_reg.original_rate_code,
          status_reg.recovered_length_code,
          status_reg.max_length_select};
        default:           reg_rdata <= 8'h00; // Unmapped reads zero.
      endcase
    end
  end

  // Receiver flags, registered as levels.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '{unlock: 1'b1, invalid: 1'b0, link_error_flag: 1'b0};
    end else begin
      flags.unlock          <= rx_unlocked;
      flags.invalid         <= rx_data_invalid;
      flags.link_error_flag <= preamble_err | parity_err |
                               biphase_err;
    end
  end

  // Pin outputs for the flags; hardware mode borrows the control pins.
  always_comb begin
    general_output_pin  = flags.link_error_flag;
    chip_select_pin     = flags.unlock;
    chip_select_pin_oe  = hw_mode;
    serial_clock_pin    = flags.link_error_flag;
    serial_clock_pin_oe = hw_mode;
  end

  // Truncation stage for the audio interface.
  ssr_truncate #(
    .SAMPLE_W (SAMPLE_W)
  ) u_truncate (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .truncation_override (truncation_override),
    .status              (status_reg),
    .sample_in           (sample_in),
    .sample_in_valid     (sample_in_valid),
    .sample_out          (sample_out),
    .sample_out_valid    (sample_out_valid)
  );

  // The write port exists for bus symmetry only.
  logic unused_wr;
  assign unused_wr = reg_wr ^ (^reg_wdata);

endmodule // ssr_status_regs

// ### test/ssr_status_regs_properties.sv
// Port-level properties of the receiver status register bank.
// Assumes binding to the bank's top module in one clock domain.
module ssr_status_regs_properties
  import ssr_pkg::*;
#(parameter int SAMPLE_W = SSR_SAMPLE_W) (
  // Watched ports.
  input wire logic                core_clk, arst_n, reg_rd, hw_mode,
  input wire logic                rx_unlocked, rx_data_invalid, parity_err,
  input wire logic                preamble_err, biphase_err, cs_bit_valid,
  input wire logic                cs_subframe_a, truncation_override,
  input wire logic                sample_in_valid, sample_out_valid,
  input wire logic                status_block_update_irq, chip_select_pin,
  input wire logic                chip_select_pin_oe, serial_clock_pin,
  input wire logic                serial_clock_pin_oe, general_output_pin,
  input wire logic [7:0]          reg_addr, reg_rdata,
  input wire logic [SAMPLE_W-1:0] sample_in, sample_out,
  input wire ssr_flags_t          flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // The internal reset copy clears two edges after release, so the
  // timing checks wait until this counter saturates.
  logic [1:0] up_reg;
  wire        live   = (up_reg == 2'h3);
  wire        mapped = (reg_addr == 8'h10) || (reg_addr == 8'h11);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) up_reg <= 2'h0;
    else if (!live) up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A status register read taken while the bit stream is idle.
  sequence s_read;
    live && reg_rd && mapped && !cs_bit_valid ##1 !cs_bit_valid;
  endsequence
  property p_unlock; live |-> flags.unlock == $past(rx_unlocked); endproperty
  a_unlock: assert property (p_unlock) else $error("unlock lag");
  property p_inv; live |-> flags.invalid == $past(rx_data_invalid); endproperty
  a_inv: assert property (p_inv) else $error("invalid lag");
  property p_err; live |-> flags.link_error_flag ==
    $past(preamble_err || parity_err || biphase_err); endproperty
  a_err: assert property (p_err) else $error("error flag");
  property p_gpo; general_output_pin == flags.link_error_flag; endproperty
  a_gpo: assert property (p_gpo) else $error("output pin");
  property p_csb; chip_select_pin == flags.unlock &&
    chip_select_pin_oe == hw_mode; endproperty
  a_csb: assert property (p_csb) else $error("select pin");
  property p_sclk; serial_clock_pin == flags.link_error_flag &&
    serial_clock_pin_oe == hw_mode; endproperty
  a_sclk: assert property (p_sclk) else $error("clock pin");
  property p_ovr; live && sample_in_valid && truncation_override |=>
    sample_out_valid && sample_out == $past(sample_in); endproperty
  a_ovr: assert property (p_ovr) else $error("override");
  property p_unmap; live && reg_rd && !mapped |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_irq_set; $rose(status_block_update_irq) |->
    $past(cs_bit_valid && cs_subframe_a) ||
    $past(cs_bit_valid && cs_subframe_a, 2); endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq set");
  property p_irq_clr; s_read |-> ##[0:1] !status_block_update_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq clr");
endmodule // ssr_status_regs_properties

bind ssr_status_regs ssr_status_regs_properties #(.SAMPLE_W(SAMPLE_W))
  u_props (.*);

// ### test/ssr_source_model.sv
// Source-side model that streams channel status blocks to the bank.
// Assumes the testbench calls send from its main sequence.
module ssr_source_model (
  // Clock from the bench.
  input  wire logic core_clk,
  // Recovered status stream.
  output logic      cs_bit,
  output logic      cs_bit_valid,
  output logic      cs_block_start,
  output logic      cs_subframe_a
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cs_bit, cs_bit_valid, cs_block_start, cs_subframe_a} = 4'h0;
  // Each bit goes out for the first channel, then inverted for the
  // second, so capturing the wrong channel corrupts the registers.
  task automatic send(input logic [39:0] blk, input logic slow);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      {cs_bit, cs_bit_valid, cs_subframe_a} = {blk[i], 2'h3};
      cs_block_start = (i == 0);
      @(negedge core_clk);
      {cs_bit, cs_subframe_a, cs_block_start} = {~blk[i], 2'h0};
      if (slow) begin
        // Idle gaps still toggle the data line; it is not held there.
        @(negedge core_clk);
        {cs_bit, cs_bit_valid} = {blk[i], 1'b0};
      end
    end
    @(negedge core_clk);
    cs_bit_valid = 1'b0;
    @(negedge core_clk);
  endtask
endmodule // ssr_source_model

// ### test/ssr_status_regs_tb.sv
// Self-checking bench for the receiver channel status register bank.
// Assumes the source model and the bound property checker.
module ssr_status_regs_tb
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, arst_n, reg_rd, reg_wr, truncation_override;
  logic        rx_unlocked, rx_data_invalid, preamble_err, parity_err;
  logic        biphase_err, hw_mode, sample_in_valid, sample_out_valid;
  logic        status_block_update_irq, general_output_pin, rd_d, rd_dd;
  logic        chip_select_pin, chip_select_pin_oe, serial_clock_pin;
  logic        serial_clock_pin_oe, cs_bit, cs_bit_valid, cs_block_start;
  logic        cs_subframe_a;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [23:0] sample_in, sample_out, rq[$], aq[$];
  logic [39:0] cur;  // Status block the bank should now hold.
  ssr_flags_t  flags;
  int          failures, checked;

  ssr_status_regs DUT (.*);
  ssr_source_model src (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Read data stands one edge after the strobe is taken.
  always @(posedge core_clk) {rd_dd, rd_d} <= {rd_d, reg_rd};
  always @(negedge core_clk) begin
    if (rd_dd) cmp(24'(reg_rdata), rq.size() ? rq.pop_front() : 'x);
    if (sample_out_valid) cmp(sample_out, aq.size() ? aq.pop_front() : 'x);
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Kept-bit mask for the length fields of a block.
  function automatic logic [23:0] keep(input logic [39:0] b);
    int w;
    case (b[35:33])
      3'h1: w = b[32] ? 20 : 16;
      3'h2: w = b[32] ? 22 : 18;
      3'h4: w = b[32] ? 23 : 19;
      3'h5: w = b[32] ? 24 : 20;
      3'h6: w = b[32] ? 21 : 17;
      default: w = 24;
    endcase
    return 24'hffffff << (24 - w);
  endfunction
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    rq.push_back(24'(e));
    @(negedge core_clk);
    reg_rd = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // Random audio with random flag inputs and pin mode alongside.
  task automatic audio(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      {sample_in, truncation_override, hw_mode} = 26'($urandom);
      {rx_unlocked, rx_data_invalid, preamble_err} = 3'($urandom);
      {parity_err, biphase_err, sample_in_valid} = {2'($urandom), 1'b1};
      aq.push_back(truncation_override ? sample_in : sample_in & keep(cur));
    end
    @(negedge core_clk);
    sample_in_valid = 1'b0;
  endtask
  task automatic rst_seq(input int n);
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (n) @(negedge core_clk);
    {arst_n, cur} = {1'b1, 8'h01, 8'h31, 24'h0};
    repeat (3) @(negedge core_clk);
  endtask
  task automatic results();
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    logic [39:0] b;
    logic        dif;
    {arst_n, reg_rd, reg_wr, truncation_override, sample_in_valid} = '0;
    {rx_unlocked, rx_data_invalid, preamble_err, parity_err} = '0;
    {biphase_err, hw_mode, reg_addr, reg_wdata, sample_in} = '0;
    {failures, checked} = '0;
    void'($urandom(32'h04bb));
    rst_seq(12);
    rd(8'h10, 8'h31);
    rd(8'h11, 8'h01);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h31);
    rd(8'h12, 8'h00);
    // Every length code with both range settings.
    for (int i = 0; i < 16; i++) begin
      b = 40'({$urandom, $urandom});
      {b[35:32], b[31:30]} = {i[3:0], 2'h0};
      dif = (b[39:24] !== cur[39:24]);
      src.send(b, i[1]);
      cmp(24'(status_block_update_irq), 24'(dif));
      cur = b;
      rd(8'h10, {2'h0, b[29:24]});
      rd(8'h11, b[39:32]);
      cmp(24'(status_block_update_irq), 24'h0);
      src.send(b, 1'b0);
      cmp(24'(status_block_update_irq), 24'h0);
      audio(6);
    end
    rst_seq(2);
    rd(8'h10, 8'h31);
    rd(8'h11, 8'h01);
    repeat (2) @(negedge core_clk);
    results();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule // ssr_status_regs_tb
